/* cswc_top.sv */
`default_nettype none

module cswc_top
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic boot_width_pin,
    input wire logic ext_access,
    input wire logic area2_match,
    input wire logic area3_match,
    output logic area2_select_strobe_n,
    output logic area3_select_strobe_n,
    output logic [1:0] area_bus_8bit,
    output logic [1:0][2:0] area_wait_cycles,
    output logic [1:0] area_ext_wait,
    output logic [1:0][1:0] area_recovery_cycles,
    output logic area2_space_select
);
    import cswc_pkg::*;

    // ****************************************************************
    // Bus slave: address phase decode
    // ****************************************************************
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic wr_pend_q;
    logic rd_data_q;
    logic [31:0] hrdata_q;
    logic strap_done_q;
    logic strap_level_q;
    logic [1:0] illegal_q;
    logic cs2_q;
    logic cs3_q;
    logic [1:0] bus8_q;
    logic [1:0][2:0] waitc_q;
    logic [1:0] extw_q;
    logic [1:0][1:0] recov_q;
    logic space_q;

    wire logic taken;
    wire logic hit_ctrl;
    wire logic hit_stat;
    wire logic wr_take;
    wire logic rd_take;
    wire logic [31:0] stat_word;
    wire logic [31:0] rd_mux;
    wire logic [1:0] illegal_w;
    wire logic [1:0][2:0] waitc_w;
    wire logic [1:0] extw_w;
    wire logic [1:0][1:0] recov_w;
    wire logic en2;
    wire logic en3;
    wire logic cs2_w;
    wire logic cs3_w;

    function automatic logic [31:0] field_word(input logic [31:0] w, input int area);
        field_word = w >> (area * AREA_STRIDE);
    endfunction

    assign taken = hsel & htrans[1] & hready;
    assign hit_ctrl = (haddr == CTRL_ADDR);
    assign hit_stat = (haddr == STAT_ADDR);
    assign wr_take = taken & hwrite & hit_ctrl;
    assign rd_take = taken & ~hwrite;

    // The write lands one cycle after its address phase, so a read that
    // follows back to back must see the incoming value, hence ctrl_d.
    assign ctrl_d = wr_pend_q ? (hwdata & CTRL_WMASK) : ctrl_q;

    assign stat_word = {28'h0, strap_level_q, strap_done_q, illegal_q};
    // Unmapped addresses read zero and writes to them are dropped.
    assign rd_mux = hit_ctrl ? ctrl_d : (hit_stat ? stat_word : 32'h0);

    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_q;

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wr_pend_q <= 1'b0;
        else
            wr_pend_q <= wr_take;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_data_q <= 1'b0;
        else
            rd_data_q <= rd_take;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0;
        else if (rd_take)
            hrdata_q <= rd_mux;
    end

    // The width strap is sampled on the first edge after reset release;
    // no bus write can land that early, so the strap never loses a race.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_q <= CTRL_RESET;
        else if (!strap_done_q)
            ctrl_q[F_WIDTH] <= boot_width_pin;
        else
            ctrl_q <= ctrl_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            strap_done_q <= 1'b0;
        else
            strap_done_q <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            strap_level_q <= 1'b0;
        else if (!strap_done_q)
            strap_level_q <= boot_width_pin;
    end

    // ****************************************************************
    // Per-area decode
    // ****************************************************************
    for (genvar i = 0; i < 2; i++)
    begin : g_area
        wire logic [31:0] fw;
        assign fw = field_word(ctrl_q, i);
        cswc_area_decode u_dec (
            .wait_code(fw[F_WAIT_LSB +: 4]),
            .waveform(fw[F_WAVE_LSB +: 2]),
            .recovery(fw[F_RECOV_LSB +: 2]),
            .wait_cycles(waitc_w[i]),
            .ext_wait(extw_w[i]),
            .recovery_cycles(recov_w[i]),
            .illegal(illegal_w[i])
        );

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                bus8_q[i] <= 1'b0;
                waitc_q[i] <= WAIT_RESET_CYCLES;
                extw_q[i] <= 1'b0;
                recov_q[i] <= RECOV_RESET_CYCLES;
                illegal_q[i] <= 1'b0;
            end
            else
            begin
                bus8_q[i] <= fw[F_WIDTH];
                waitc_q[i] <= waitc_w[i];
                extw_q[i] <= extw_w[i];
                recov_q[i] <= recov_w[i];
                illegal_q[i] <= illegal_w[i];
            end
        end
    end

    // ****************************************************************
    // Chip-select strobes
    // ****************************************************************
    assign en2 = ctrl_q[F_ENABLE];
    assign en3 = ctrl_q[AREA_STRIDE + F_ENABLE];
    // In whole-space mode area 2 catches every access that area 3 leaves.
    assign cs3_w = ext_access & en3 & area3_match;
    assign cs2_w = ext_access & en2 &
                   (ctrl_q[F_SPACE] ? area2_match : ~cs3_w);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cs2_q <= 1'b0;
            cs3_q <= 1'b0;
            space_q <= 1'b0;
        end
        else
        begin
            cs2_q <= cs2_w;
            cs3_q <= cs3_w;
            space_q <= ctrl_q[F_SPACE];
        end
    end

    assign area2_select_strobe_n = ~cs2_q;
    assign area3_select_strobe_n = ~cs3_q;
    assign area_bus_8bit = bus8_q;
    assign area_wait_cycles = waitc_q;
    assign area_ext_wait = extw_q;
    assign area_recovery_cycles = recov_q;
    assign area2_space_select = space_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_width_out_tracks: assert property (
        strap_done_q |=> area_bus_8bit[1] == $past(ctrl_q[AREA_STRIDE + F_WIDTH])
    ) else $error("area 3 width output does not follow its field");

    a_wait_fixed_count: assert property (
        !ctrl_q[3] |=> area_wait_cycles[0] == $past(ctrl_q[2:0]) && !area_ext_wait[0]
    ) else $error("area 2 fixed wait count wrong");

    a_wait_ext_mode: assert property (
        ctrl_q[19:16] == 4'hf |=> area_wait_cycles[1] == 3'h1 && area_ext_wait[1]
    ) else $error("area 3 extended wait not one plus external");

    a_wave_forbidden: assert property (
        ctrl_q[7:6] != 2'h0 |=> stat_word[0]
    ) else $error("forbidden waveform code not flagged");

    a_enable_gates_cs: assert property (
        !ctrl_q[F_ENABLE] |=> area2_select_strobe_n
    ) else $error("disabled area 2 drove its strobe");

    a_space_whole: assert property (
        ext_access && en2 && !ctrl_q[F_SPACE] && !(area3_match && en3)
        |=> !area2_select_strobe_n
    ) else $error("area 2 whole-space decode missed an access");

    a_recovery_map: assert property (
        ctrl_q[9:8] == 2'h2 |=> area_recovery_cycles[0] == 2'h0
    ) else $error("recovery code 10 did not give zero dummy cycles");

    a_reset_defaults: assert property (
        !strap_done_q |-> ctrl_q[3:0] == 4'h5 && ctrl_q[19:16] == 4'h5
            && ctrl_q[9:6] == 4'h0 && ctrl_q[25:20] == 6'h0
    ) else $error("reset defaults wrong");

    a_strap_capture: assert property (
        !strap_done_q |=> ctrl_q[F_WIDTH] == $past(boot_width_pin)
    ) else $error("area 2 width did not take the boot pin level");

    a_read_follows: assert property (
        rd_take && hit_ctrl && !wr_pend_q |=> hrdata == $past(ctrl_q)
    ) else $error("control read back returned wrong data");

    a_write_lands: assert property (
        wr_take && strap_done_q |=> ##1 ctrl_q == ($past(hwdata) & CTRL_WMASK)
    ) else $error("control write did not land");

    a_width_area2: assert property (
        strap_done_q |=> area_bus_8bit[0] == $past(ctrl_q[F_WIDTH])
    ) else $error("area 2 width output does not follow its field");

    a_wait_bad_code: assert property (
        ctrl_q[3] && ctrl_q[3:0] != 4'hf |=> area_wait_cycles[0] == 3'h0
            && !area_ext_wait[0] && stat_word[0]
    ) else $error("forbidden wait code not flagged or not zeroed");

    a_recovery_two: assert property (
        ctrl_q[25:24] == 2'h0 |=> area_recovery_cycles[1] == 2'h2
    ) else $error("recovery code 00 did not give two dummy cycles");

    a_recovery_bad: assert property (
        ctrl_q[9:8] == 2'h3 |=> area_recovery_cycles[0] == 2'h2 && stat_word[0]
    ) else $error("forbidden recovery code not flagged or not safe");

    a_area3_gate: assert property (
        !en3 |=> area3_select_strobe_n
    ) else $error("disabled area 3 drove its strobe");

    a_strobe_idle: assert property (
        !ext_access |=> area2_select_strobe_n && area3_select_strobe_n
    ) else $error("strobe driven without an external access");

    a_space_window: assert property (
        ext_access && en2 && ctrl_q[F_SPACE]
        |=> area2_select_strobe_n == !$past(area2_match)
    ) else $error("area 2 restricted decode does not follow its match");

    a_space_out: assert property (
        strap_done_q |=> area2_space_select == $past(ctrl_q[F_SPACE])
    ) else $error("area 2 space output does not follow its field");

    a_strap_level: assert property (
        !strap_done_q |=> stat_word[3] == $past(boot_width_pin)
    ) else $error("status does not hold the sampled boot pin level");

    a_read_data_holds: assert property (
        !rd_data_q |-> $stable(hrdata)
    ) else $error("read data changed without a read");

endmodule

`default_nettype wire

/* cswc_pkg.sv */
// Function
// - Each area's width bit: 0 gives a 16-bit data bus, 1 gives 8 bits.
// - Wait codes 0000-0111 give that many waits; 1111 gives one plus external.
// - Waveform field must be 00 (ROM/RAM); other codes are forbidden.
// - Area enable gates its strobe; area 2 resets enabled, area 3 disabled.
// - Area-2 space bit: 0 covers the whole 4-Gbyte space, 1 its own space. At 0 the code leaves out accesses that an enabled area 3 matches.
// - Read recovery: 00 two dummy cycles, 01 one, 10 none, 11 forbidden.
// - Area-2 width bit takes the boot width pin level at reset.
`default_nettype none

package cswc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [31:0] CTRL_ADDR = 32'hffff_e484;
    localparam logic [31:0] STAT_ADDR = 32'hffff_e4c0;

    // ****************************************************************
    // Field layout; area 3 repeats area 2 one half-word higher
    // ****************************************************************
    localparam int AREA_STRIDE = 16;
    localparam int F_WAIT_LSB = 0;
    localparam int F_WIDTH = 4;
    localparam int F_WAVE_LSB = 6;
    localparam int F_RECOV_LSB = 8;
    localparam int F_SPACE = 10;
    localparam int F_ENABLE = 11;

    localparam logic [31:0] CTRL_WMASK = 32'h0bdf_0fdf;
    localparam logic [31:0] CTRL_RESET = 32'h0005_0805;

    // ****************************************************************
    // Status bits
    // ****************************************************************
    localparam int S_ILLEGAL_LSB = 0;
    localparam int S_STRAP_DONE = 2;
    localparam int S_STRAP_LEVEL = 3;

    // ****************************************************************
    // Code points
    // ****************************************************************
    localparam logic [3:0] WAIT_EXTENDED = 4'hf;
    localparam logic [2:0] WAIT_EXT_BASE = 3'h1;
    localparam logic [1:0] WAVE_ROM_RAM = 2'h0;
    localparam logic [1:0] RECOV_TWO = 2'h0;
    localparam logic [1:0] RECOV_ONE = 2'h1;
    localparam logic [1:0] RECOV_NONE = 2'h2;
    localparam logic [2:0] WAIT_RESET_CYCLES = 3'h5;
    localparam logic [1:0] RECOV_RESET_CYCLES = 2'h2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

`default_nettype wire

/* cswc_area_decode.sv */
`default_nettype none

module cswc_area_decode
    import cswc_pkg::*;
(
    input wire logic [3:0] wait_code,
    input wire logic [1:0] waveform,
    input wire logic [1:0] recovery,
    output logic [2:0] wait_cycles,
    output logic ext_wait,
    output logic [1:0] recovery_cycles,
    output logic illegal
);

    wire logic wait_fixed;
    wire logic wait_ext;
    wire logic recov_bad;

    assign wait_fixed = ~wait_code[3];
    assign wait_ext = (wait_code == WAIT_EXTENDED);

    // A forbidden wait code falls back to zero waits; it is flagged below.
    assign wait_cycles = wait_fixed ? wait_code[2:0] :
                         (wait_ext ? WAIT_EXT_BASE : 3'h0);
    assign ext_wait = wait_ext;

    // Code 11 keeps the longest recovery, so a bad setting errs on safety.
    assign recovery_cycles = (recovery == RECOV_ONE) ? 2'h1 :
                             (recovery == RECOV_NONE) ? 2'h0 : 2'h2;
    assign recov_bad = (recovery == 2'h3);

    assign illegal = (~wait_fixed & ~wait_ext) | recov_bad
                   | (waveform != WAVE_ROM_RAM);

endmodule

`default_nettype wire

/* cswc_mem_model.sv */
`default_nettype none

module cswc_mem_model
(
    input wire logic hclk,
    input wire logic sel2_n,
    input wire logic sel3_n,
    output logic [7:0] n2,
    output logic [7:0] n3
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] c2_q = 8'h00;
    logic [7:0] c3_q = 8'h00;
    // The devices only count selected cycles; the bench compares deltas, so no reset.
    always @(posedge hclk)
    begin
        if (sel2_n === 1'b0)
            c2_q <= c2_q + 8'h01;
        if (sel3_n === 1'b0)
            c3_q <= c3_q + 8'h01;
    end
    assign n2 = c2_q;
    assign n3 = c3_q;
endmodule

`default_nettype wire

/* chip_select_wait_config_tb_top.sv */
`default_nettype none

module chip_select_wait_config_tb_top;
    import cswc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic pin = 1'b1;
    logic ext = 1'b0;
    logic m2 = 1'b0;
    logic m3 = 1'b0;
    wire logic hready;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic s2_n;
    wire logic s3_n;
    wire logic space;
    wire logic [1:0] b8;
    wire logic [1:0] xw;
    wire logic [1:0][2:0] wc;
    wire logic [1:0][1:0] rc;
    wire logic [7:0] n2;
    wire logic [7:0] n3;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [31:0] w;
    logic [3:0] c2;
    logic [3:0] c3;

    cswc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .boot_width_pin(pin), .ext_access(ext), .area2_match(m2), .area3_match(m3),
        .area2_select_strobe_n(s2_n), .area3_select_strobe_n(s3_n),
        .area_bus_8bit(b8), .area_wait_cycles(wc), .area_ext_wait(xw),
        .area_recovery_cycles(rc), .area2_space_select(space));
    cswc_mem_model mem (.hclk(hclk), .sel2_n(s2_n), .sel3_n(s3_n), .n2(n2), .n3(n3));

    always #10 hclk = ~hclk;

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails = fails + 1;
            wrap_up();
        end
    end

    // ****************************************************************
    // Expected port values from a control word
    // ****************************************************************
    function automatic logic [2:0] ew(input logic [3:0] c);
        return (c == 4'hf) ? 3'h1 : (c[3] ? 3'h0 : c[2:0]);
    endfunction
    function automatic logic [1:0] er(input logic [1:0] r);
        return (r == 2'h2) ? 2'h0 : ((r == 2'h1) ? 2'h1 : 2'h2);
    endfunction
    function automatic logic [14:0] eo(input logic [31:0] c);
        return {c[10], c[20], c[4], c[19:16] == 4'hf, c[3:0] == 4'hf,
            ew(c[19:16]), ew(c[3:0]), er(c[25:24]), er(c[9:8])};
    endfunction

    // ****************************************************************
    // Bus and check tasks
    // ****************************************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
    endtask
    task automatic cfg(input logic [31:0] d);
        xfer(1'b1, CTRL_ADDR, d);
        repeat (2) @(posedge hclk);
        #1;
    endtask
    task automatic co(input logic [31:0] c);
        chk("outs", 32'(eo(c)), 32'({space, b8, xw, wc, rc}));
    endtask
    task automatic stat(input logic [1:0] e);
        xfer(1'b0, STAT_ADDR, 32'h0);
        chk("status", 32'({pin, 1'b1, e}), 32'(rd[3:0]));
    endtask
    task automatic pulse(input logic a2, input logic a3, input logic [7:0] e2,
        input logic [7:0] e3);
        logic [7:0] b2;
        logic [7:0] b3;
        b2 = n2;
        b3 = n3;
        @(posedge hclk);
        ext <= 1'b1;
        m2 <= a2;
        m3 <= a3;
        repeat (3) @(posedge hclk);
        ext <= 1'b0;
        m2 <= 1'b0;
        m3 <= 1'b0;
        repeat (3) @(posedge hclk);
        #1;
        chk("sel2", 32'(e2), 32'(n2 - b2));
        chk("sel3", 32'(e3), 32'(n3 - b3));
    endtask
    task automatic do_reset(input logic p);
        hresetn <= 1'b0;
        pin <= p;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    initial
    begin
        do_reset(1'b1);
        rdchk("ctrl", CTRL_ADDR, CTRL_RESET | 32'h10);
        co(CTRL_RESET | 32'h10);
        for (int i = 0; i < 9; i++)
        begin
            c2 = (i == 8) ? 4'hf : 4'(i);
            c3 = (i == 0) ? 4'hf : 4'(8 - i);
            w = {6'h0, 2'(i % 3), 3'h0, ~i[0], c3, 6'h2, 2'((i + 1) % 3), 3'h0, i[0], c2};
            cfg(w);
            rdchk("ctrl", CTRL_ADDR, w);
            co(w);
        end
        // Every bit set: reserved bits must stay clear and the illegal flags rise.
        cfg(32'hffff_ffff);
        rdchk("ctrl", CTRL_ADDR, CTRL_WMASK);
        co(CTRL_WMASK);
        stat(2'h3);
        cfg(32'h0008_0808);
        co(32'h0008_0808);
        stat(2'h3);
        cfg(32'h0000_0840);
        stat(2'h1);
        rdchk("unmapped", 32'hffff_e400, 32'h0);
        cfg(CTRL_RESET);
        pulse(1'b0, 1'b1, 8'h3, 8'h0);
        cfg(CTRL_RESET | 32'h0800_0000);
        pulse(1'b0, 1'b1, 8'h0, 8'h3);
        cfg(CTRL_RESET | 32'h400);
        pulse(1'b0, 1'b0, 8'h0, 8'h0);
        pulse(1'b1, 1'b0, 8'h3, 8'h0);
        cfg(32'h0000_0400);
        pulse(1'b1, 1'b0, 8'h0, 8'h0);
        do_reset(1'b0);
        rdchk("ctrl", CTRL_ADDR, CTRL_RESET);
        stat(2'h0);
        wrap_up();
    end
endmodule

`default_nettype wire
